/* File: rtl/smc_dev.sv */
// Device end: modem handshake lines and the nine general purpose lines.
// Assumes firmware reaches settings registers through the set_* port.
// Behaviour
// - Handshake lines low means asserted
// - Data lines rest high when idle
// - Ring low while remote sets up connection
// - Carrier detect low while connection live
// - Host terminal-ready drives peer-ready input
// - Host holds peer-ready low in high-speed mode
// - Peer-ready release drops link or requests command
// - Lines settable input/output, weak/strong pulls; strength is only held in setting 626 and never applied to the lines
// - Reset: all lines inputs, weak pull-down
// - Lines reached via settings 621 to 628
// - Fourth line lights lamp on logic one
// - Third line doubles as terminal-ready, settings 552/553
// - Analogue readings via seven-hundred settings
//
// Chosen here: the register offsets and the APB interface to the registers.
module smc_dev
  import smc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  smc_link_if.dev link,
  input wire logic remote_attempt,
  input wire logic link_live,
  input wire logic tx_busy,
  input wire logic tx_bit,
  input wire logic rx_ready,
  input wire logic [SMC_ADC_W-1:0] adc0,
  input wire logic [SMC_ADC_W-1:0] adc1,
  input wire logic set_valid,
  input wire logic set_write,
  input wire logic [SMC_SNUM_W-1:0] set_num,
  input wire logic [SMC_SDATA_W-1:0] set_wdata,
  output logic [SMC_SDATA_W-1:0] set_rdata,
  output logic set_ack,
  output logic set_err,
  output logic drop_req,
  output logic cmd_req,
  output logic lamp_on,
  output logic rx_bit,
  output logic cts_ok
);
  // ==========================================================
  // Settings state
  logic [SMC_LINES-1:0] dir_q, dir_d, dout_q, dout_d, pen_q, pen_d;
  logic [SMC_LINES-1:0] pup_q, pup_d, pstr_q, pstr_d;
  logic [1:0] hs_q, hs_d;
  logic dtr_en_q, dtr_en_d, dtr_mode_q, dtr_mode_d;
  logic [SMC_SDATA_W-1:0] rdata_q, rdata_d;
  logic ack_q, ack_d, err_q, err_d;
  logic wr;
  smc_conn_t state_q, state_d;

  // A request is held until acknowledged; it is taken once, on the edge after ack is low
  assign wr = set_valid & set_write & ~ack_q;

  // Write decode and read mux for settings registers
  always_comb begin
    dir_d = dir_q;
    dout_d = dout_q;
    pen_d = pen_q;
    pup_d = pup_q;
    pstr_d = pstr_q;
    hs_d = hs_q;
    dtr_en_d = dtr_en_q;
    dtr_mode_d = dtr_mode_q;
    rdata_d = '0;
    err_d = 1'b0;
    ack_d = set_valid & ~ack_q;
    if (set_valid && !ack_q) begin
      unique case (set_num)
        SMC_S_DIR: begin
          if (wr) dir_d = set_wdata[SMC_LINES-1:0];
          rdata_d = SMC_SDATA_W'(dir_q);
        end
        SMC_S_DOUT: begin
          if (wr) dout_d = set_wdata[SMC_LINES-1:0];
          rdata_d = SMC_SDATA_W'(dout_q);
        end
        SMC_S_DIN: begin
          rdata_d = SMC_SDATA_W'(link.line);
        end
        SMC_S_PEN: begin
          if (wr) pen_d = set_wdata[SMC_LINES-1:0];
          rdata_d = SMC_SDATA_W'(pen_q);
        end
        SMC_S_PUP: begin
          if (wr) pup_d = set_wdata[SMC_LINES-1:0];
          rdata_d = SMC_SDATA_W'(pup_q);
        end
        SMC_S_PSTR: begin
          if (wr) pstr_d = set_wdata[SMC_LINES-1:0];
          rdata_d = SMC_SDATA_W'(pstr_q);
        end
        SMC_S_LAMP: begin
          if (wr) dout_d[SMC_LAMP_IDX] = set_wdata[0];
          rdata_d = SMC_SDATA_W'(link.line[SMC_LAMP_IDX]);
        end
        SMC_S_LINK: begin
          rdata_d = SMC_SDATA_W'({~link.peer_ready_in_n, state_q == SMC_LIVE,
                                  state_q == SMC_RING});
        end
        SMC_S_HSMODE: begin
          if (wr) hs_d = set_wdata[1:0];
          rdata_d = SMC_SDATA_W'(hs_q);
        end
        SMC_S_DTR_EN: begin
          if (wr) dtr_en_d = set_wdata[0];
          rdata_d = SMC_SDATA_W'(dtr_en_q);
        end
        SMC_S_DTR_MODE: begin
          if (wr) dtr_mode_d = set_wdata[0];
          rdata_d = SMC_SDATA_W'(dtr_mode_q);
        end
        SMC_S_ADC0: rdata_d = SMC_SDATA_W'(adc0);
        SMC_S_ADC1: rdata_d = SMC_SDATA_W'(adc1);
        default: err_d = 1'b1;
      endcase
    end
  end

  // Reset leaves every line an input with a weak pull-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= SMC_DIR_RST;
      dout_q <= SMC_DIR_RST;
      pen_q <= SMC_PEN_RST;
      pup_q <= SMC_PUP_RST;
      pstr_q <= SMC_PSTR_RST;
      hs_q <= SMC_HS_OFF;
      dtr_en_q <= 1'b0;
      dtr_mode_q <= 1'b0;
      rdata_q <= '0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      dir_q <= dir_d;
      dout_q <= dout_d;
      pen_q <= pen_d;
      pup_q <= pup_d;
      pstr_q <= pstr_d;
      hs_q <= hs_d;
      dtr_en_q <= dtr_en_d;
      dtr_mode_q <= dtr_mode_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  // ==========================================================
  // Connection tracking and handshake lines
  logic ri_n_q, ri_n_d, dcd_n_q, dcd_n_d, pr_n_q;
  logic drop_q, drop_d, cmd_q, cmd_d;
  logic tx_q, tx_d, rts_n_q, rts_n_d, rx_q, cts_q;
  logic [SMC_LINES-1:0] go_q, go_d, goe_q, goe_d;
  logic lamp_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SMC_IDLE: begin
        if (link_live) state_d = SMC_LIVE;
        else if (remote_attempt) state_d = SMC_RING;
      end
      SMC_RING: begin
        if (link_live) state_d = SMC_LIVE;
        else if (!remote_attempt) state_d = SMC_IDLE;
      end
      SMC_LIVE: begin
        // A new attempt pending at link end rings at once rather than a cycle late
        if (!link_live) state_d = remote_attempt ? SMC_RING : SMC_IDLE;
      end
    endcase
    ri_n_d = (state_d != SMC_RING);
    dcd_n_d = (state_d != SMC_LIVE);
    // Release of peer-ready is a rising edge; only acted on while live
    drop_d = 1'b0;
    cmd_d = 1'b0;
    if (link.peer_ready_in_n && !pr_n_q && state_q == SMC_LIVE) begin
      drop_d = (hs_q == SMC_HS_DROP);
      cmd_d = (hs_q == SMC_HS_CMD);
    end
    tx_d = tx_busy ? tx_bit : 1'b1;
    rts_n_d = ~rx_ready;
    // Pin drive; the third line is taken over when terminal-ready is on
    go_d = dout_q;
    goe_d = dir_q;
    if (dtr_en_q) begin
      goe_d[SMC_DTR_IDX] = 1'b1;
      go_d[SMC_DTR_IDX] = dtr_mode_q ? 1'b0 : (state_d != SMC_LIVE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SMC_IDLE;
      ri_n_q <= 1'b1;
      dcd_n_q <= 1'b1;
      pr_n_q <= 1'b1;
      drop_q <= 1'b0;
      cmd_q <= 1'b0;
      tx_q <= 1'b1;
      rts_n_q <= 1'b1;
      rx_q <= 1'b1;
      cts_q <= 1'b0;
      go_q <= SMC_DIR_RST;
      goe_q <= SMC_DIR_RST;
      lamp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ri_n_q <= ri_n_d;
      dcd_n_q <= dcd_n_d;
      pr_n_q <= link.peer_ready_in_n;
      drop_q <= drop_d;
      cmd_q <= cmd_d;
      tx_q <= tx_d;
      rts_n_q <= rts_n_d;
      rx_q <= link.host_tx;
      cts_q <= ~link.host_cts_n;
      go_q <= go_d;
      goe_q <= goe_d;
      lamp_q <= link.line[SMC_LAMP_IDX];
    end
  end

  // Pulls are exported so the wire model can resolve undriven lines
  assign link.ring_indicate_n = ri_n_q;
  assign link.carrier_detect_n = dcd_n_q;
  assign link.dev_tx = tx_q;
  assign link.dev_rts_n = rts_n_q;
  assign link.dev_o = go_q;
  assign link.dev_oe = goe_q;
  assign link.pull_en = pen_q;
  assign link.pull_up = pup_q;
  assign set_rdata = rdata_q;
  assign set_ack = ack_q;
  assign set_err = err_q;
  assign drop_req = drop_q;
  assign cmd_req = cmd_q;
  assign lamp_on = lamp_q;
  assign rx_bit = rx_q;
  assign cts_ok = cts_q;
endmodule

/* File: rtl/smc_pkg.sv */
// Constants shared by the serial modem control device end and host end.
// Assumes one clock domain, pclk, and an active-low asynchronous reset.
package smc_pkg;
  // ==========================================================
  // Widths
  localparam int SMC_LINES = 9;
  localparam int SMC_SNUM_W = 10;
  localparam int SMC_SDATA_W = 16;
  localparam int SMC_ADC_W = 8;
  localparam int SMC_DTR_IDX = 2;
  localparam int SMC_LAMP_IDX = 3;
  // ==========================================================
  // Settings register numbers on the device
  localparam logic [9:0] SMC_S_HSMODE = 10'h01fb;  // 507
  localparam logic [9:0] SMC_S_DTR_EN = 10'h0228;  // 552
  localparam logic [9:0] SMC_S_DTR_MODE = 10'h0229;  // 553
  localparam logic [9:0] SMC_S_DIR = 10'h026d;  // 621
  localparam logic [9:0] SMC_S_DOUT = 10'h026e;  // 622
  localparam logic [9:0] SMC_S_DIN = 10'h026f;  // 623
  localparam logic [9:0] SMC_S_PEN = 10'h0270;  // 624
  localparam logic [9:0] SMC_S_PUP = 10'h0271;  // 625
  localparam logic [9:0] SMC_S_PSTR = 10'h0272;  // 626
  localparam logic [9:0] SMC_S_LAMP = 10'h0273;  // 627
  localparam logic [9:0] SMC_S_LINK = 10'h0274;  // 628
  localparam logic [9:0] SMC_S_ADC0 = 10'h02bd;  // 701
  localparam logic [9:0] SMC_S_ADC1 = 10'h02be;  // 702
  // ==========================================================
  // Reset values of the general purpose lines
  localparam logic [8:0] SMC_DIR_RST = 9'h000;  // All inputs
  localparam logic [8:0] SMC_PEN_RST = 9'h1ff;  // Pulls enabled
  localparam logic [8:0] SMC_PUP_RST = 9'h000;  // Pull-downs
  localparam logic [8:0] SMC_PSTR_RST = 9'h000;  // Weak
  // High-speed mode actions on peer-ready deassertion
  localparam logic [1:0] SMC_HS_OFF = 2'h0;
  localparam logic [1:0] SMC_HS_DROP = 2'h1;
  localparam logic [1:0] SMC_HS_CMD = 2'h2;
  // ==========================================================
  // Host APB register offsets and control bits
  localparam logic [11:0] SMC_A_CTRL = 12'h000;
  localparam logic [11:0] SMC_A_STAT = 12'h004;
  localparam logic [11:0] SMC_A_GOUT = 12'h008;
  localparam logic [11:0] SMC_A_GOE = 12'h00c;
  localparam logic [11:0] SMC_A_GIN = 12'h010;
  localparam int SMC_C_TRDY = 0;
  localparam int SMC_C_CTS = 1;
  localparam logic [31:0] SMC_ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {SMC_IDLE, SMC_RING, SMC_LIVE} smc_conn_t;
endpackage

/* File: rtl/smc_link_if.sv */
// Pins between the device end and the host end of the serial port.
// Assumes both ends run on the same pclk; resolves the shared lines.
interface smc_link_if;
  import smc_pkg::*;
  logic ring_indicate_n;
  logic carrier_detect_n;
  logic peer_ready_in_n;
  logic dev_tx;
  logic dev_rts_n;
  logic host_tx;
  logic host_cts_n;
  logic [SMC_LINES-1:0] dev_o;
  logic [SMC_LINES-1:0] dev_oe;
  logic [SMC_LINES-1:0] pull_en;
  logic [SMC_LINES-1:0] pull_up;
  logic [SMC_LINES-1:0] host_o;
  logic [SMC_LINES-1:0] host_oe;
  logic [SMC_LINES-1:0] line;

  // ==========================================================
  // Wire level: a driver wins, else the pull, else low
  always_comb begin
    for (int i = 0; i < SMC_LINES; i++) begin
      if (dev_oe[i]) begin
        line[i] = dev_o[i];
      end else if (host_oe[i]) begin
        line[i] = host_o[i];
      end else begin
        line[i] = pull_en[i] & pull_up[i];
      end
    end
  end

  modport dev (output ring_indicate_n, output carrier_detect_n, input peer_ready_in_n,
    output dev_tx, output dev_rts_n, input host_tx, input host_cts_n,
    output dev_o, output dev_oe, output pull_en, output pull_up, input line);
  modport host (input ring_indicate_n, input carrier_detect_n, output peer_ready_in_n,
    input dev_tx, input dev_rts_n, output host_tx, output host_cts_n,
    output host_o, output host_oe, input line);
endinterface

/* File: rtl/smc_host.sv */
// Host end: an APB slave whose registers drive the host side of the port.
// Assumes an APB master on pclk; no UART engine, data lines stay idle.
module smc_host
  import smc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  smc_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ==========================================================
  // APB slave: one wait state, answers with pready in second access cycle
  logic [1:0] ctrl_q, ctrl_d;
  logic [SMC_LINES-1:0] gout_q, gout_d, goe_q, goe_d, gin_q;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d, err_q, err_d, hit;
  logic [4:0] stat_q;

  always_comb begin
    ctrl_d = ctrl_q;
    gout_d = gout_q;
    goe_d = goe_q;
    rdata_d = rdata_q;
    err_d = err_q;
    rdy_d = psel & penable & ~rdy_q;
    hit = 1'b1;
    unique case (paddr)
      SMC_A_CTRL: rdata_d = 32'(ctrl_q);
      SMC_A_STAT: rdata_d = 32'(stat_q);
      SMC_A_GOUT: rdata_d = 32'(gout_q);
      SMC_A_GOE: rdata_d = 32'(goe_q);
      SMC_A_GIN: rdata_d = 32'(gin_q);
      default: begin
        rdata_d = SMC_ZERO32;
        hit = 1'b0;
      end
    endcase
    if (!rdy_d) rdata_d = rdata_q;
    if (rdy_d) err_d = ~hit;
    // Writes land on the edge that samples pready high
    if (psel && penable && rdy_q && pwrite) begin
      unique case (paddr)
        SMC_A_CTRL: ctrl_d = pwdata[1:0];
        SMC_A_GOUT: gout_d = pwdata[SMC_LINES-1:0];
        SMC_A_GOE: goe_d = pwdata[SMC_LINES-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      gout_q <= '0;
      goe_q <= '0;
      rdata_q <= SMC_ZERO32;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      gout_q <= gout_d;
      goe_q <= goe_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // ==========================================================
  // Status sampling; handshake levels decoded to active high
  logic pr_n_q, cts_n_q, tx_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      gin_q <= '0;
      pr_n_q <= 1'b1;
      cts_n_q <= 1'b1;
      tx_q <= 1'b1;
    end else begin
      stat_q <= {link.dev_tx, ~link.line[SMC_DTR_IDX], ~link.dev_rts_n,
                 ~link.carrier_detect_n, ~link.ring_indicate_n};
      gin_q <= link.line;
      pr_n_q <= ~ctrl_q[SMC_C_TRDY];
      cts_n_q <= ~ctrl_q[SMC_C_CTS];
      tx_q <= 1'b1;
    end
  end

  assign link.peer_ready_in_n = pr_n_q;
  assign link.host_cts_n = cts_n_q;
  assign link.host_tx = tx_q;
  assign link.host_o = gout_q;
  assign link.host_oe = goe_q;
  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
endmodule

/* File: verification/smc_props.sv */
// Checker for the link between the serial modem device end and host end.
// Assumes one clock, pclk, and presetn; tb_top instantiates it by the link.
module smc_props
  import smc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ring_indicate_n,
  input wire logic carrier_detect_n,
  input wire logic peer_ready_in_n,
  input wire logic dev_tx,
  input wire logic dev_rts_n,
  input wire logic host_tx,
  input wire logic host_cts_n,
  input wire logic [SMC_LINES-1:0] dev_oe,
  input wire logic [SMC_LINES-1:0] pull_en,
  input wire logic [SMC_LINES-1:0] pull_up,
  input wire logic [SMC_LINES-1:0] line,
  input wire logic remote_attempt,
  input wire logic link_live,
  input wire logic drop_req,
  input wire logic cmd_req,
  input wire logic lamp_on
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // First edge after reset, flops still hold reset values
  sequence s_out_of_rst;
    $rose(presetn);
  endsequence
  // Remote peer setting up a link
  sequence s_attempt;
    remote_attempt && !link_live;
  endsequence

  a_ring_on_attempt: assert property (s_attempt |=> !ring_indicate_n)
    else $error("ring not asserted during attempt");
  a_ring_release: assert property (!(remote_attempt && !link_live) |=> ring_indicate_n)
    else $error("ring asserted without attempt");
  a_carrier_live: assert property (link_live |=> !carrier_detect_n)
    else $error("carrier not asserted while live");
  a_carrier_drop: assert property ($fell(link_live) |=> carrier_detect_n)
    else $error("carrier held after link end");
  a_reset_idle: assert property (s_out_of_rst |-> ring_indicate_n && carrier_detect_n
    && peer_ready_in_n && host_cts_n && dev_rts_n && dev_tx && host_tx)
    else $error("handshake or data line not idle after reset");
  a_reset_lines: assert property (s_out_of_rst |-> dev_oe == '0 && (&pull_en)
    && pull_up == '0 && line == '0)
    else $error("general lines not weak pull-down inputs after reset");
  a_host_tx_idle: assert property (host_tx)
    else $error("host data line left idle level");
  a_lamp_follow: assert property (1'b1 |=> lamp_on == $past(line[SMC_LAMP_IDX]))
    else $error("lamp does not follow fourth line");
  a_req_pulse: assert property ((drop_req || cmd_req) |=> !(drop_req || cmd_req))
    else $error("drop or command request wider than one cycle");
  a_req_cause: assert property ((drop_req || cmd_req) |-> peer_ready_in_n
    && !(drop_req && cmd_req))
    else $error("request without peer-ready release");
endmodule

/* File: verification/tb_top.sv */
// Bench joining device end and host end through the link interface.
// Assumes smc_pkg; host reached over APB, device through its settings port.
module tb_top
  import smc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic remote_attempt = 1'b0;
  logic link_live = 1'b0;
  logic tx_busy = 1'b0;
  logic tx_bit = 1'b1;
  logic rx_ready = 1'b0;
  logic [SMC_ADC_W-1:0] adc0 = 8'h5a;
  logic [SMC_ADC_W-1:0] adc1 = 8'hc3;
  logic set_valid = 1'b0;
  logic set_write = 1'b0;
  logic [SMC_SNUM_W-1:0] set_num = '0;
  logic [SMC_SDATA_W-1:0] set_wdata = '0;
  logic [SMC_SDATA_W-1:0] set_rdata;
  logic set_ack, set_err, drop_req, cmd_req, lamp_on, rx_bit, cts_ok;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int samples_checked = 0;
  int n_drop, n_cmd;
  logic [9:0] rnum [4] = '{SMC_S_DIR, SMC_S_PEN, SMC_S_PUP, SMC_S_PSTR};
  logic [8:0] rval [4] = '{9'h000, 9'h1ff, 9'h000, 9'h000};

  smc_link_if link ();
  smc_dev smc_dev_i (.pclk(pclk), .presetn(presetn), .link(link),
    .remote_attempt(remote_attempt), .link_live(link_live), .tx_busy(tx_busy),
    .tx_bit(tx_bit), .rx_ready(rx_ready), .adc0(adc0), .adc1(adc1), .set_valid(set_valid),
    .set_write(set_write), .set_num(set_num), .set_wdata(set_wdata), .set_rdata(set_rdata),
    .set_ack(set_ack), .set_err(set_err), .drop_req(drop_req), .cmd_req(cmd_req),
    .lamp_on(lamp_on), .rx_bit(rx_bit), .cts_ok(cts_ok));
  smc_host smc_host_i (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  smc_props smc_props_i (.pclk(pclk), .presetn(presetn),
    .ring_indicate_n(link.ring_indicate_n), .carrier_detect_n(link.carrier_detect_n),
    .peer_ready_in_n(link.peer_ready_in_n), .dev_tx(link.dev_tx), .dev_rts_n(link.dev_rts_n),
    .host_tx(link.host_tx), .host_cts_n(link.host_cts_n), .dev_oe(link.dev_oe),
    .pull_en(link.pull_en), .pull_up(link.pull_up), .line(link.line),
    .remote_attempt(remote_attempt), .link_live(link_live), .drop_req(drop_req),
    .cmd_req(cmd_req), .lamp_on(lamp_on));

  // ==========================================================
  // Clock, 100 ns period
  initial begin
    forever #50 pclk = ~pclk;
  end

  // ==========================================================
  // Reporting
  task automatic close_out();
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A hung handshake ends the run rather than the whole simulation stalling
  task automatic ran_out();
    fail_count++;
    $display("[ERR] %0t handshake wait ran out", $time);
    close_out();
  endtask

  // ==========================================================
  // Access tasks: APB to the host end, settings port to the device end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) ran_out();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dset(input logic wr, input logic [9:0] num, input logic [15:0] wd);
    int n;
    @(posedge pclk);
    set_valid <= 1'b1;
    set_write <= wr;
    set_num <= num;
    set_wdata <= wd;
    // Request stands until the edge that samples set_ack high; data taken there
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (set_ack !== 1'b1 && n < 8);
    if (set_ack !== 1'b1) ran_out();
    rd = {16'h0000, set_rdata};
    er = set_err;
    set_valid <= 1'b0;
  endtask
  // Link state changes reach the handshake lines one edge later; allow settling
  task automatic link_set(input logic att, input logic live);
    @(posedge pclk);
    remote_attempt <= att;
    link_live <= live;
    repeat (3) @(negedge pclk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({link.ring_indicate_n, link.carrier_detect_n, link.peer_ready_in_n}, 3'h7);
    chk({link.dev_tx, link.host_tx, rx_bit}, 3'h7);
    chk(link.line, 9'h000);
    for (int i = 0; i < 4; i++) begin
      dset(1'b0, rnum[i], '0);
      chk(rd, 32'(rval[i]));
    end
    $display("Test reset defaults done");
    // Device drives lines, host reads them; lamp follows the fourth line
    dset(1'b1, SMC_S_DOUT, 16'h00a5);
    dset(1'b1, SMC_S_DIR, 16'h01ff);
    apb(1'b0, SMC_A_GIN, '0);
    chk(rd, 32'h0000_00a5);
    dset(1'b0, SMC_S_DIN, '0);
    chk(rd, 32'h0000_00a5);
    chk(lamp_on, 1'h0);
    dset(1'b1, SMC_S_DOUT, 16'h0008);
    repeat (3) @(negedge pclk);
    chk(lamp_on, 1'h1);
    dset(1'b0, SMC_S_LAMP, '0);
    chk(rd, 32'h0000_0001);
    dset(1'b1, SMC_S_DIR, '0);
    dset(1'b1, SMC_S_PUP, 16'h01ff);
    apb(1'b0, SMC_A_GIN, '0);
    chk(rd, 32'h0000_01ff);
    dset(1'b1, SMC_S_PUP, '0);
    apb(1'b1, SMC_A_GOE, 32'h0000_0008);
    apb(1'b1, SMC_A_GOUT, 32'h0000_0008);
    repeat (3) @(negedge pclk);
    chk(lamp_on, 1'h1);
    apb(1'b1, SMC_A_GOE, '0);
    dset(1'b1, 10'h3ff, 16'h1234);
    chk(er, 1'h1);
    apb(1'b0, 12'hffc, '0);
    chk(er, 1'h1);
    dset(1'b0, SMC_S_ADC0, '0);
    chk(rd, 32'h0000_005a);
    dset(1'b0, SMC_S_ADC1, '0);
    chk(rd, 32'h0000_00c3);
    $display("Test general lines done");
    // Abandoned attempt, then a completed one, then link end
    link_set(1'b1, 1'b0);
    chk({link.ring_indicate_n, link.carrier_detect_n}, 2'h1);
    link_set(1'b0, 1'b0);
    chk({link.ring_indicate_n, link.carrier_detect_n}, 2'h3);
    link_set(1'b1, 1'b0);
    link_set(1'b1, 1'b1);
    chk({link.ring_indicate_n, link.carrier_detect_n}, 2'h2);
    link_set(1'b0, 1'b0);
    chk({link.ring_indicate_n, link.carrier_detect_n}, 2'h3);
    // Third line as terminal-ready, both behaviours
    dset(1'b1, SMC_S_DTR_EN, 16'h0001);
    dset(1'b1, SMC_S_DTR_MODE, '0);
    link_set(1'b0, 1'b1);
    apb(1'b0, SMC_A_GIN, '0);
    chk(rd[SMC_DTR_IDX], 1'h0);
    link_set(1'b0, 1'b0);
    apb(1'b0, SMC_A_GIN, '0);
    chk(rd[SMC_DTR_IDX], 1'h1);
    dset(1'b1, SMC_S_DTR_MODE, 16'h0001);
    apb(1'b0, SMC_A_GIN, '0);
    chk(rd[SMC_DTR_IDX], 1'h0);
    // Status: tx idle, terminal-ready asserted, rts, carrier and ring off
    apb(1'b0, SMC_A_STAT, '0);
    chk(rd, 32'h0000_0018);
    dset(1'b1, SMC_S_DTR_EN, '0);
    $display("Test ring carrier done");
    // Handshake levels: low is asserted
    @(posedge pclk);
    rx_ready <= 1'b1;
    tx_busy <= 1'b1;
    tx_bit <= 1'b0;
    apb(1'b1, SMC_A_CTRL, 32'h0000_0003);
    repeat (3) @(negedge pclk);
    chk({link.peer_ready_in_n, link.host_cts_n, cts_ok}, 3'h1);
    chk({link.dev_rts_n, link.dev_tx}, 2'h0);
    @(posedge pclk);
    tx_busy <= 1'b0;
    repeat (3) @(negedge pclk);
    chk(link.dev_tx, 1'h1);
    // Peer-ready release in each high-speed mode
    for (int m = 0; m < 3; m++) begin
      dset(1'b1, SMC_S_HSMODE, 16'(m));
      apb(1'b1, SMC_A_CTRL, 32'h0000_0001);
      link_set(1'b0, 1'b1);
      // Link status: peer ready, live, not ringing
      dset(1'b0, SMC_S_LINK, '0);
      chk(rd, 32'h0000_0006);
      apb(1'b1, SMC_A_CTRL, 32'h0000_0000);
      n_drop = 0;
      n_cmd = 0;
      repeat (10) begin
        @(negedge pclk);
        n_drop += int'(drop_req === 1'b1);
        n_cmd += int'(cmd_req === 1'b1);
      end
      chk({n_drop[7:0], n_cmd[7:0]}, {8'(m == 1), 8'(m == 2)});
      link_set(1'b0, 1'b0);
    end
    $display("Test handshake done");
    close_out();
  end
endmodule
